// ==== eadc_regs.vh ====
`ifndef EADC_REGS_VH
`define EADC_REGS_VH

// ----------------------------------------------------------------
// Access sizes
// ----------------------------------------------------------------
`define EADC_SIZE_BYTE 2'h0
`define EADC_SIZE_WORD 2'h1
`define EADC_SIZE_LONG 2'h2

// ----------------------------------------------------------------
// Trace selections
// ----------------------------------------------------------------
`define EADC_TRACE_FG 2'h0
`define EADC_TRACE_BG 2'h1
`define EADC_TRACE_BOTH 2'h2

// ----------------------------------------------------------------
// Reset values of the shadow configuration
// ----------------------------------------------------------------
`define EADC_RST_BASE 32'h00000000
`define EADC_RST_SSP 32'h00000000
`define EADC_RST_PC 32'h00000000
`define EADC_RST_PORTA_ADDR 1'h0
`define EADC_RST_SIZE 2'h0
`define EADC_RST_TRACE 2'h0

// ----------------------------------------------------------------
// Field positions and vector table
// ----------------------------------------------------------------
`define EADC_VALID_BIT 0
`define EADC_NUM_CS 4
`define EADC_VEC_SSP 24'h000000
`define EADC_VEC_PC 24'h000004

`endif

// ==== eadc_addr_shadow.v ====
`timescale 1ns/1ps
`include "eadc_regs.vh"

module eadc_addr_shadow (
    input wire clock,
    input wire rst,
    input wire ce,
    input wire [7:0] port_a,
    input wire [7:0] port_b,
    input wire porta_is_addr,
    input wire [127:0] cs_base,
    output reg [7:0] mapper_addr_hi,
    output reg [7:0] analyzer_addr_hi,
    output reg boot_chip_select
);

// ----------------------------------------------------------------
// Upper address rebuild from chip-select programming
// ----------------------------------------------------------------
// Chip selects arrive on the low nibble of the second port, active low.
wire [`EADC_NUM_CS-1:0] cs_hit;
wire [7:0] cs_hi [0:`EADC_NUM_CS-1];
genvar g;
generate
    for (g = 0; g < `EADC_NUM_CS; g = g + 1) begin : g_cs
        assign cs_hit[g] = ~port_b[g] & cs_base[32*g + `EADC_VALID_BIT];
        assign cs_hi[g] = cs_base[32*g+31:32*g+24];
    end
endgenerate

reg [7:0] next_mapper_addr_hi;
always @* begin
    next_mapper_addr_hi = 8'h00;
    if (porta_is_addr) begin
        next_mapper_addr_hi = port_a;
    end else if (cs_hit[0]) begin
        next_mapper_addr_hi = cs_hi[0];
    end else if (cs_hit[1]) begin
        next_mapper_addr_hi = cs_hi[1];
    end else if (cs_hit[2]) begin
        next_mapper_addr_hi = cs_hi[2];
    end else if (cs_hit[3]) begin
        next_mapper_addr_hi = cs_hi[3];
    end
end

always @(posedge clock) begin
    if (rst) begin
        mapper_addr_hi <= 8'h00;
        analyzer_addr_hi <= 8'h00;
        boot_chip_select <= 1'h0;
    end else if (ce) begin
        mapper_addr_hi <= next_mapper_addr_hi;
        // The analyzer always sees the boot base, even with address outputs.
        analyzer_addr_hi <= cs_hi[0];
        boot_chip_select <= cs_hit[0];
    end
end

endmodule // eadc_addr_shadow

// ==== eadc_access_sizer.v ====
`timescale 1ns/1ps
`include "eadc_regs.vh"

module eadc_access_sizer (
    input wire clock,
    input wire rst,
    input wire ce,
    input wire [1:0] size_sel,
    input wire acc_req,
    input wire acc_write,
    input wire [31:0] acc_addr,
    input wire [31:0] acc_data,
    input wire cyc_done,
    output reg acc_busy,
    output reg cyc_valid,
    output reg cyc_write,
    output reg [31:0] cyc_addr,
    output reg [31:0] cyc_data,
    output reg [1:0] cyc_size
);

reg [1:0] left;
reg [31:0] shift;

// ----------------------------------------------------------------
// Split a long value into cycles of the selected size
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (rst) begin
        acc_busy <= 1'h0;
        cyc_valid <= 1'h0;
        cyc_write <= 1'h0;
        cyc_addr <= 32'h00000000;
        cyc_data <= 32'h00000000;
        cyc_size <= `EADC_SIZE_BYTE;
        left <= 2'h0;
        shift <= 32'h00000000;
    end else if (ce) begin
        if (!acc_busy && acc_req) begin
            acc_busy <= 1'h1;
            cyc_valid <= 1'h1;
            cyc_write <= acc_write;
            cyc_addr <= acc_addr;
            cyc_size <= size_sel;
            case (size_sel)
                `EADC_SIZE_BYTE: begin
                    cyc_data <= {24'h000000, acc_data[31:24]};
                    shift <= {acc_data[23:0], 8'h00};
                    left <= 2'h3;
                end
                `EADC_SIZE_WORD: begin
                    cyc_data <= {16'h0000, acc_data[31:16]};
                    shift <= {acc_data[15:0], 16'h0000};
                    left <= 2'h1;
                end
                default: begin
                    cyc_data <= acc_data;
                    shift <= 32'h00000000;
                    left <= 2'h0;
                end
            endcase
        end else if (acc_busy && cyc_done) begin
            if (left == 2'h0) begin
                acc_busy <= 1'h0;
                cyc_valid <= 1'h0;
            end else begin
                left <= left - 2'h1;
                if (cyc_size == `EADC_SIZE_BYTE) begin
                    cyc_addr <= cyc_addr + 32'h00000001;
                    cyc_data <= {24'h000000, shift[31:24]};
                    shift <= {shift[23:0], 8'h00};
                end else begin
                    cyc_addr <= cyc_addr + 32'h00000002;
                    cyc_data <= {16'h0000, shift[31:16]};
                    shift <= {shift[15:0], 16'h0000};
                end
            end
        end
    end
end

endmodule // eadc_access_sizer

// ==== eadc_top.v ====
`timescale 1ns/1ps
`include "eadc_regs.vh"


module eadc_top (
    input wire clock,
    input wire rst,
    input wire ce,
    input wire [7:0] pin_port_a,
    input wire [7:0] pin_port_b,
    input wire pin_target_reset,
    input wire cfg_load,
    input wire cfg_porta_is_addr,
    input wire [127:0] cfg_cs_base,
    input wire [31:0] cfg_module_base,
    input wire [31:0] cfg_reset_ssp,
    input wire [31:0] cfg_reset_pc,
    input wire [1:0] cfg_access_size,
    input wire cfg_rom_break_en,
    input wire [1:0] cfg_trace_mode,
    input wire bg_monitor,
    input wire emu_reset_req,
    input wire run_from_reset_cmd,
    input wire run_cmd,
    input wire break_cmd,
    input wire vec_rd_done,
    input wire [31:0] vec_rd_data,
    input wire user_write,
    input wire region_is_rom,
    input wire region_writable,
    input wire cyc_is_background,
    input wire cyc_is_mem,
    input wire acc_req,
    input wire acc_write,
    input wire [31:0] acc_addr,
    input wire [31:0] acc_data,
    input wire cyc_done,
    output wire [7:0] mapper_addr_hi,
    output wire [7:0] analyzer_addr_hi,
    output wire boot_chip_select,
    output reg regs_load,
    output reg [31:0] ssp_value,
    output reg [31:0] pc_value,
    output reg sync_to_integration,
    output reg monitor_active,
    output reg run_active,
    output reg break_to_monitor,
    output reg rom_write_commit,
    output reg trace_capture,
    output reg vec_rd_req,
    output reg [31:0] vec_rd_addr,
    output reg shadow_base_valid,
    output wire acc_busy,
    output wire cyc_valid,
    output wire cyc_write,
    output wire [31:0] cyc_addr,
    output wire [31:0] cyc_data,
    output wire [1:0] cyc_size
);

localparam S_RESET = 3'h0;
localparam S_LOAD_CFG = 3'h1;
localparam S_SYNC = 3'h2;
localparam S_MONITOR = 3'h3;
localparam S_VEC_SSP = 3'h4;
localparam S_VEC_PC = 3'h5;
localparam S_RUN = 3'h6;

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
reg [7:0] pa_s1;
reg [7:0] pa_s2;
reg [7:0] pb_s1;
reg [7:0] pb_s2;
reg tr_s1;
reg tr_s2;

always @(posedge clock) begin
    if (rst) begin
        pa_s1 <= 8'h00;
        pa_s2 <= 8'h00;
        pb_s1 <= 8'hff;
        pb_s2 <= 8'hff;
        tr_s1 <= 1'h0;
        tr_s2 <= 1'h0;
    end else if (ce) begin
        pa_s1 <= pin_port_a;
        pa_s2 <= pa_s1;
        pb_s1 <= pin_port_b;
        pb_s2 <= pb_s1;
        tr_s1 <= pin_target_reset;
        tr_s2 <= tr_s1;
    end
end

// ----------------------------------------------------------------
// Shadow configuration
// ----------------------------------------------------------------
reg sh_porta_is_addr;
reg [127:0] sh_cs_base;
reg [31:0] sh_module_base;
reg [31:0] sh_reset_ssp;
reg [31:0] sh_reset_pc;
reg [1:0] sh_access_size;
reg sh_rom_break_en;
reg [1:0] sh_trace_mode;
reg [2:0] state;

wire running = (state == S_RUN);

always @(posedge clock) begin
    if (rst) begin
        sh_porta_is_addr <= `EADC_RST_PORTA_ADDR;
        sh_cs_base <= {4{`EADC_RST_BASE}};
        sh_module_base <= `EADC_RST_BASE;
        sh_reset_ssp <= `EADC_RST_SSP;
        sh_reset_pc <= `EADC_RST_PC;
        sh_access_size <= `EADC_RST_SIZE;
        sh_rom_break_en <= 1'h0;
        sh_trace_mode <= `EADC_RST_TRACE;
        shadow_base_valid <= 1'h0;
    end else if (ce) begin
        // A load is refused while the user program runs.
        if (cfg_load && !running) begin
            sh_porta_is_addr <= cfg_porta_is_addr;
            sh_cs_base <= cfg_cs_base;
            sh_module_base <= cfg_module_base;
            sh_reset_ssp <= cfg_reset_ssp;
            sh_reset_pc <= cfg_reset_pc;
            sh_access_size <= cfg_access_size;
            sh_rom_break_en <= cfg_rom_break_en;
            sh_trace_mode <= cfg_trace_mode;
        end
        shadow_base_valid <= sh_module_base[`EADC_VALID_BIT];
    end
end

eadc_addr_shadow u_shadow (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .port_a(pa_s2),
    .port_b(pb_s2),
    .porta_is_addr(sh_porta_is_addr),
    .cs_base(sh_cs_base),
    .mapper_addr_hi(mapper_addr_hi),
    .analyzer_addr_hi(analyzer_addr_hi),
    .boot_chip_select(boot_chip_select)
);

eadc_access_sizer u_sizer (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .size_sel(sh_access_size),
    .acc_req(acc_req & ~running),
    .acc_write(acc_write),
    .acc_addr(acc_addr),
    .acc_data(acc_data),
    .cyc_done(cyc_done),
    .acc_busy(acc_busy),
    .cyc_valid(cyc_valid),
    .cyc_write(cyc_write),
    .cyc_addr(cyc_addr),
    .cyc_data(cyc_data),
    .cyc_size(cyc_size)
);

// ----------------------------------------------------------------
// Reset, monitor and run sequencing
// ----------------------------------------------------------------
wire rom_break = running && user_write && region_is_rom && sh_rom_break_en;

always @(posedge clock) begin
    if (rst) begin
        state <= S_RESET;
        regs_load <= 1'h0;
        ssp_value <= 32'h00000000;
        pc_value <= 32'h00000000;
        sync_to_integration <= 1'h0;
        monitor_active <= 1'h0;
        run_active <= 1'h0;
        break_to_monitor <= 1'h0;
        vec_rd_req <= 1'h0;
        vec_rd_addr <= 32'h00000000;
    end else if (ce) begin
        regs_load <= 1'h0;
        sync_to_integration <= 1'h0;
        break_to_monitor <= 1'h0;
        case (state)
            S_RESET: begin
                if (!emu_reset_req) begin
                    if (run_from_reset_cmd) begin
                        state <= S_VEC_SSP;
                        vec_rd_req <= 1'h1;
                        vec_rd_addr <= {sh_cs_base[31:24], `EADC_VEC_SSP};
                    end else begin
                        state <= S_LOAD_CFG;
                    end
                end
            end
            S_LOAD_CFG: begin
                ssp_value <= {sh_reset_ssp[31:1], 1'b0};
                pc_value <= {sh_reset_pc[31:1], 1'b0};
                regs_load <= 1'h1;
                state <= S_SYNC;
            end
            S_SYNC: begin
                sync_to_integration <= 1'h1;
                break_to_monitor <= 1'h1;
                monitor_active <= 1'h1;
                state <= S_MONITOR;
            end
            S_MONITOR: begin
                // An emulator reset in the monitor returns to S_RESET and reloads the registers; the target reset pin does not.
                if (emu_reset_req) begin
                    monitor_active <= 1'h0;
                    state <= S_RESET;
                end else if (run_cmd) begin
                    monitor_active <= 1'h0;
                    run_active <= 1'h1;
                    state <= S_RUN;
                end
            end
            S_VEC_SSP: begin
                if (vec_rd_done) begin
                    ssp_value <= vec_rd_data;
                    vec_rd_addr <= {sh_cs_base[31:24], `EADC_VEC_PC};
                    state <= S_VEC_PC;
                end
            end
            S_VEC_PC: begin
                if (vec_rd_done) begin
                    pc_value <= vec_rd_data;
                    vec_rd_req <= 1'h0;
                    regs_load <= 1'h1;
                    run_active <= 1'h1;
                    state <= S_RUN;
                end
            end
            S_RUN: begin
                if (emu_reset_req) begin
                    run_active <= 1'h0;
                    state <= S_RESET;
                end else if (rom_break || break_cmd) begin
                    break_to_monitor <= 1'h1;
                    run_active <= 1'h0;
                    monitor_active <= 1'h1;
                    state <= S_MONITOR;
                end
            end
            default: begin
                state <= S_RESET;
            end
        endcase
    end
end

// ----------------------------------------------------------------
// ROM write pass-through and trace qualifier
// ----------------------------------------------------------------
always @(posedge clock) begin
    if (rst) begin
        rom_write_commit <= 1'h0;
        trace_capture <= 1'h0;
    end else if (ce) begin
        // The write goes ahead whether or not it also breaks.
        rom_write_commit <= user_write && region_is_rom && region_writable;
        case (sh_trace_mode)
            `EADC_TRACE_FG: trace_capture <= ~cyc_is_background;
            `EADC_TRACE_BG: trace_capture <= cyc_is_background & cyc_is_mem;
            `EADC_TRACE_BOTH: trace_capture <= ~cyc_is_background | cyc_is_mem;
            default: trace_capture <= 1'h0;
        endcase
    end
end

// Stack pointer placement is the operator's duty, as is matching setup.
// The synchronised target reset deliberately leaves the stack pointer and PC alone.
wire unused_target_reset = tr_s2 & bg_monitor;

endmodule // eadc_top

// ==== eadc_top_sva.sv ====
`timescale 1ns/1ps
module eadc_top_sva (
    input wire clock,
    input wire rst,
    input wire ce,
    input wire cfg_load,
    input wire [127:0] cfg_cs_base,
    input wire cfg_rom_break_en,
    input wire [1:0] cfg_trace_mode,
    input wire emu_reset_req,
    input wire run_from_reset_cmd,
    input wire pin_target_reset,
    input wire break_cmd,
    input wire user_write,
    input wire region_is_rom,
    input wire region_writable,
    input wire cyc_is_background,
    input wire cyc_is_mem,
    input wire acc_req,
    input wire [31:0] acc_addr,
    input wire [7:0] analyzer_addr_hi,
    input wire regs_load,
    input wire [31:0] ssp_value,
    input wire [31:0] pc_value,
    input wire sync_to_integration,
    input wire monitor_active,
    input wire run_active,
    input wire break_to_monitor,
    input wire rom_write_commit,
    input wire trace_capture,
    input wire vec_rd_req,
    input wire [31:0] vec_rd_addr,
    input wire acc_busy,
    input wire cyc_valid,
    input wire [31:0] cyc_addr
);
    // --------------------------------
    // Local copy of the shadow setup
    // --------------------------------
    logic [7:0] s_cs0;
    logic [1:0] s_trc;
    logic s_brk;
    logic trc_exp;
    always @(posedge clock) begin
        if (rst) begin
            s_cs0 <= 8'h00;
            s_trc <= 2'h0;
            s_brk <= 1'h0;
        end else if (ce && cfg_load && !run_active) begin
            s_cs0 <= cfg_cs_base[31:24];
            s_trc <= cfg_trace_mode;
            s_brk <= cfg_rom_break_en;
        end
    end
    assign trc_exp = (s_trc == 2'h0) ? !cyc_is_background :
        (s_trc == 2'h1) ? (cyc_is_background && cyc_is_mem) :
        (s_trc == 2'h2) ? (!cyc_is_background || cyc_is_mem) : 1'h0;
    default clocking @(posedge clock); endclocking
    default disable iff (rst || !ce);
    property p_analyzer;
        analyzer_addr_hi == $past(s_cs0);
    endproperty
    a_analyzer: assert property (p_analyzer) else $error("analyzer byte wrong");
    property p_seq;
        $fell(emu_reset_req) && !run_from_reset_cmd |-> ##[1:3] regs_load
            ##1 (monitor_active && sync_to_integration && break_to_monitor);
    endproperty
    a_seq: assert property (p_seq) else $error("monitor entry wrong");
    property p_rfr;
        $fell(emu_reset_req) && run_from_reset_cmd |-> ##[1:2]
            (vec_rd_req && vec_rd_addr == {s_cs0, 24'h000000}) ##[1:40] (regs_load && run_active);
    endproperty
    a_rfr: assert property (p_rfr) else $error("vector fetch wrong");
    property p_tgt_rst;
        monitor_active && pin_target_reset && !emu_reset_req && !regs_load
            |=> $stable(ssp_value) && $stable(pc_value);
    endproperty
    a_tgt_rst: assert property (p_tgt_rst) else $error("target reset moved regs");
    property p_acc;
        acc_req && !acc_busy && !run_active |=> cyc_valid && acc_busy && cyc_addr == $past(acc_addr);
    endproperty
    a_acc: assert property (p_acc) else $error("access not started");
    property p_rom_break;
        run_active && user_write && region_is_rom && s_brk |=> break_to_monitor && monitor_active;
    endproperty
    a_rom_break: assert property (p_rom_break) else $error("no rom break");
    property p_rom_commit;
        user_write && region_is_rom && region_writable |=> rom_write_commit;
    endproperty
    a_rom_commit: assert property (p_rom_commit) else $error("rom write lost");
    property p_rom_quiet;
        run_active && user_write && region_is_rom && !s_brk && !break_cmd && !emu_reset_req
            |=> !break_to_monitor && run_active;
    endproperty
    a_rom_quiet: assert property (p_rom_quiet) else $error("unwanted break");
    property p_trace;
        !$past(rst) && $past(ce) |-> trace_capture == $past(trc_exp);
    endproperty
    a_trace: assert property (p_trace) else $error("trace select wrong");
    c_rom_break: cover property (run_active && user_write && region_is_rom && s_brk);
    c_rfr: cover property ($fell(emu_reset_req) && run_from_reset_cmd);
    c_trace: cover property (s_trc == 2'h1 && trace_capture);
endmodule // eadc_top_sva
bind eadc_top eadc_top_sva u_sva (.*);

// ==== eadc_target_model.sv ====
`timescale 1ns/1ps
module eadc_target_model #(
    parameter logic [31:0] SSP_VAL = 32'h00002000,
    parameter logic [31:0] PC_VAL = 32'hff001000
) (
    input wire logic clock,
    input wire logic slow,
    input wire logic cyc_valid,
    input wire logic [31:0] cyc_addr,
    input wire logic [31:0] cyc_data,
    input wire logic [1:0] cyc_size,
    input wire logic vec_rd_req,
    input wire logic [31:0] vec_rd_addr,
    output logic cyc_done,
    output logic vec_rd_done,
    output logic [31:0] vec_rd_data
);
    // ----------------------------------
    // Target bus, with a log of each beat
    // ----------------------------------
    logic [31:0] la [0:15];
    logic [31:0] ld [0:15];
    logic [1:0] ls [0:15];
    int cnt = 0;
    int wt = 0;
    initial begin
        cyc_done = 1'h0;
        vec_rd_done = 1'h0;
        vec_rd_data = 32'h5a5a5a5a;
    end
    // In idle cycles and right after a done cycle the data lines toggle; they hold during wait states and beat starts.
    always @(posedge clock) begin
        if (cyc_done || vec_rd_done) begin
            cyc_done <= 1'h0;
            vec_rd_done <= 1'h0;
            vec_rd_data <= ~vec_rd_data;
        end else if (wt != 0) begin
            wt <= wt - 1;
        end else if (cyc_valid) begin
            cyc_done <= 1'h1;
            la[cnt[3:0]] <= cyc_addr;
            ld[cnt[3:0]] <= cyc_data;
            ls[cnt[3:0]] <= cyc_size;
            cnt <= cnt + 1;
            wt <= slow ? 3 : 0;
        end else if (vec_rd_req) begin
            vec_rd_done <= 1'h1;
            vec_rd_data <= vec_rd_addr[2] ? PC_VAL : SSP_VAL;
        end else begin
            vec_rd_data <= ~vec_rd_data;
        end
    end
endmodule // eadc_target_model

// ==== test_eadc_top.sv ====
`timescale 1ns/1ps
module test_eadc_top;
    logic clock = 1'h0, rst = 1'h1, ce = 1'h1, pin_target_reset = 1'h0, cfg_load = 1'h0;
    logic [7:0] pin_port_a = 8'h00, pin_port_b = 8'hff;
    logic cfg_porta_is_addr = 1'h0, cfg_rom_break_en = 1'h0, bg_monitor = 1'h1;
    logic [127:0] cfg_cs_base = 128'h0;
    logic [31:0] cfg_module_base = 32'h00100001, cfg_reset_ssp = 32'h00003ffe;
    logic [31:0] cfg_reset_pc = 32'h00001000, acc_addr = 32'h00000100, acc_data = 32'h12345678;
    logic [1:0] cfg_access_size = 2'h2, cfg_trace_mode = 2'h0;
    logic emu_reset_req = 1'h1, run_from_reset_cmd = 1'h0, run_cmd = 1'h0, break_cmd = 1'h0;
    logic user_write = 1'h0, region_is_rom = 1'h0, region_writable = 1'h0;
    logic cyc_is_background = 1'h0, cyc_is_mem = 1'h0, acc_req = 1'h0, acc_write = 1'h1;
    logic slow = 1'h0, e;
    logic [7:0] mapper_addr_hi, analyzer_addr_hi;
    logic [31:0] ssp_value, pc_value, vec_rd_addr, vec_rd_data, cyc_addr, cyc_data, x, msk;
    logic [1:0] cyc_size;
    logic boot_chip_select, regs_load, sync_to_integration, monitor_active, run_active;
    logic break_to_monitor, rom_write_commit, trace_capture, vec_rd_req, vec_rd_done;
    logic shadow_base_valid, acc_busy, cyc_valid, cyc_write, cyc_done;
    int error_cnt = 0, n_tests = 0, i, m, k;
    eadc_top uut (.*);
    eadc_target_model tm (.*);
    always #12.5 clock = ~clock;
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic load;
        cfg_load = 1'h1;
        tick(1);
        cfg_load = 1'h0;
        tick(4);
    endtask
    task automatic emu_reset(input logic rfr);
        emu_reset_req = 1'h1;
        run_from_reset_cmd = rfr;
        tick(2);
        emu_reset_req = 1'h0;
        for (i = 0; i < 50 && regs_load !== 1'h1; i++) tick(1);
        tick(2);
    endtask
    task automatic rom_write;
        {user_write, region_is_rom, region_writable} = 3'h7;
        tick(1);
        {user_write, region_is_rom, region_writable} = 3'h0;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        wrap_up();
    end
    initial begin
        tick(8);
        rst = 1'h0;
        cfg_cs_base = {64'h0, 32'h40000001, 32'hff000001};
        load();
        chk("analyzer", 8'hff, analyzer_addr_hi);
        chk("mapper", 8'h00, mapper_addr_hi);
        chk("base_valid", 1'h1, shadow_base_valid);
        pin_port_b = 8'hfd;
        tick(4);
        chk("mapper", 8'h40, mapper_addr_hi);
        chk("boot_cs", 1'h0, boot_chip_select);
        pin_port_b = 8'hfc;
        tick(4);
        chk("mapper", 8'hff, mapper_addr_hi);
        chk("boot_cs", 1'h1, boot_chip_select);
        ce = 1'h0;
        pin_port_b = 8'hfd;
        tick(4);
        chk("mapper_hold", 8'hff, mapper_addr_hi);
        ce = 1'h1;
        tick(4);
        chk("mapper", 8'h40, mapper_addr_hi);
        cfg_porta_is_addr = 1'h1;
        pin_port_a = 8'h5a;
        load();
        chk("mapper", 8'h5a, mapper_addr_hi);
        chk("analyzer", 8'hff, analyzer_addr_hi);
        cfg_cs_base[31:24] = 8'h80;
        tick(4);
        chk("analyzer", 8'hff, analyzer_addr_hi);
        load();
        chk("analyzer", 8'h80, analyzer_addr_hi);
        cfg_porta_is_addr = 1'h0;
        cfg_cs_base[31:24] = 8'hff;
        load();
        $display("test shadow done");
        emu_reset(1'h0);
        chk("ssp", 32'h00003ffe, ssp_value);
        chk("pc", 32'h00001000, pc_value);
        chk("monitor", 1'h1, monitor_active);
        pin_target_reset = 1'h1;
        tick(6);
        pin_target_reset = 1'h0;
        chk("ssp", 32'h00003ffe, ssp_value);
        chk("pc", 32'h00001000, pc_value);
        for (m = 0; m < 4; m++) begin
            cfg_trace_mode = m[1:0];
            load();
            for (k = 0; k < 4; k++) begin
                {cyc_is_background, cyc_is_mem} = k[1:0];
                tick(2);
                e = (m == 0) ? !k[1] : (m == 1) ? (k == 3) : (m == 2) ? (k != 2) : 1'h0;
                chk("trace", e, trace_capture);
            end
        end
        $display("test monitor done");
        for (m = 0; m < 3; m++) begin
            cfg_access_size = m[1:0];
            load();
            slow = (m == 0);
            k = tm.cnt;
            acc_write = (m != 1);
            acc_req = 1'h1;
            tick(1);
            acc_req = 1'h0;
            chk("cyc_write", m != 1, cyc_write);
            for (i = 0; i < 200 && acc_busy !== 1'h0; i++) tick(1);
            chk("beats", 4 >> m, tm.cnt - k);
            msk = 32'((64'h1 << (8 << m)) - 1);
            for (i = 0; i < (4 >> m); i++) begin
                x = (acc_data >> (8 * (4 - ((i + 1) << m)))) & msk;
                chk("cyc_data", x, tm.ld[k + i] & msk);
                chk("cyc_addr", 32'h00000100 + (i << m), tm.la[k + i]);
                chk("cyc_size", m, tm.ls[k + i]);
            end
        end
        $display("test sizes done");
        bg_monitor = 1'h0;
        emu_reset(1'h1);
        chk("run", 1'h1, run_active);
        chk("ssp", 32'h00002000, ssp_value);
        chk("pc", 32'hff001000, pc_value);
        rom_write();
        chk("commit", 1'h1, rom_write_commit);
        chk("break", 1'h0, break_to_monitor);
        cfg_cs_base[31:24] = 8'h80;
        load();
        chk("analyzer", 8'hff, analyzer_addr_hi);
        chk("run", 1'h1, run_active);
        cfg_cs_base[31:24] = 8'hff;
        cfg_rom_break_en = 1'h1;
        emu_reset_req = 1'h1;
        tick(2);
        load();
        emu_reset(1'h1);
        rom_write();
        chk("break", 1'h1, break_to_monitor);
        chk("commit", 1'h1, rom_write_commit);
        tick(1);
        chk("monitor", 1'h1, monitor_active);
        $display("test run done");
        wrap_up();
    end
endmodule // test_eadc_top
